// ==== shared/dpcc_regs.svh ====
// register map, field positions, reset values and timing counts of the pll clock config
`ifndef DPCC_REGS_SVH
`define DPCC_REGS_SVH

// ==========================================================
// register offsets (15-bit serial-port address)
`define DPCC_ADDR_PLL_IRQ_EN       15'h001f
`define DPCC_ADDR_PLL_IRQ_STATUS   15'h0023
`define DPCC_ADDR_SYNTH_CONTROL    15'h0083
`define DPCC_ADDR_SYNTH_STATUS     15'h0084
`define DPCC_ADDR_FEEDBACK_DIV     15'h0085
`define DPCC_ADDR_LOOP_FILTER_A    15'h0087
`define DPCC_ADDR_LOOP_FILTER_B    15'h0088
`define DPCC_ADDR_LOOP_FILTER_C    15'h0089
`define DPCC_ADDR_CP_CURRENT       15'h008a
`define DPCC_ADDR_VCO_OUT_DIV      15'h008b
`define DPCC_ADDR_REF_DIV          15'h008c
`define DPCC_ADDR_VCO_TRACK_A      15'h01b4
`define DPCC_ADDR_VCO_TRACK_B      15'h01b6
`define DPCC_ADDR_VCO_TRACK_C      15'h01bb

// ==========================================================
// field positions
`define DPCC_IRQ_LOST_BIT          4
`define DPCC_IRQ_LOCK_BIT          5
`define DPCC_CTRL_ENABLE_BIT       4
`define DPCC_CTRL_RECAL_BIT        7
`define DPCC_STAT_LOCK_BIT         1
`define DPCC_STAT_CAL_DONE_BIT     5
`define DPCC_STAT_EDGE_LO_BIT      6
`define DPCC_STAT_EDGE_HI_BIT      7

// ==========================================================
// legal ranges and band limits
`define DPCC_FB_MIN                8'h06
`define DPCC_FB_MAX                8'h7f
`define DPCC_REF_CODE_MAX          3'h4
`define DPCC_BAND_MID              9'h100
`define DPCC_BAND_MAX              9'h1ff

// ==========================================================
// reset values
`define DPCC_RST_FEEDBACK          8'h08
`define DPCC_RST_VCO_CODE          2'h1
`define DPCC_RST_REF_CODE          3'h0

// ==========================================================
// timing
`define DPCC_CAL_CYCLES            256

`endif

// ==== shared/dpcc_pkg.sv ====
// types of the pll clock config block
package dpcc_pkg;

  // ==========================================================
  // synthesizer sequencer states
  typedef enum logic [2:0] {
    DPCC_IDLE = 3'b001,
    DPCC_CAL  = 3'b010,
    DPCC_RUN  = 3'b100
  } dpcc_state_e;

  // ==========================================================
  // whole state of the block
  typedef struct packed {
    logic              sclk_d;
    logic [4:0]        bit_cnt;
    logic [23:0]       shift;
    logic [6:0]        out_sh;
    logic              sdo;
    logic              sdo_oe;
    logic [1:0]        irq_en;
    logic [1:0]        irq_src;
    logic [7:0]        ctrl;
    logic [7:0]        fb;
    logic [7:0]        lfa;
    logic [7:0]        lfb;
    logic [7:0]        lfc;
    logic [5:0]        cp;
    logic [1:0]        vco_code;
    logic [2:0]        ref_code;
    logic [7:0]        tra;
    logic [7:0]        trb;
    logic [7:0]        trc;
    logic [4:0]        ref_ratio;
    logic [4:0]        vco_ratio;
    dpcc_state_e       st;
    logic [15:0]       cal_cnt;
    logic              cal_done;
    logic              ever_en;
    logic [8:0]        band;
    logic              edge_hi;
    logic              edge_lo;
    logic              lock;
    logic              lock_d;
    logic              irq_oe;
    logic              clk_sel_pll;
  } dpcc_state_s;

endpackage

// ==== hdl/dpcc_top.sv ====
// register file, calibration sequencer and lock events of the sample-clock synthesizer
`timescale 1ns/1ns
`include "dpcc_regs.svh"
// Notes on behaviour
// [R1] sample clock comes straight from clock input or from the pll multiplier
// [R2] host should load the fixed optimisation values, e.g. loop filter a = 0x62
// [R3] five 4-bit loop filter codes are held across three loop filter registers
// [R4] charge pump current is a 6-bit code in the low bits of its register
// [R5] first enable runs charge pump calibration, then sets the calibration-done flag
// [R6] host loads all synthesizer settings before setting the enable bit
// [R7] reference divider codes 0..4 select divide by 1, 2, 4, 8, 16
// [R8] host keeps divided reference between 35 and 80 mhz
// [R9] feedback ratio is an 8-bit field accepting 6 to 127
// [R10] phase detector compares divided reference with sample clock over twice the ratio
// [R11] vco divider codes 1, 2, 3 select divide by 4, 8, 16
// [R12] host keeps vco frequency between 6 and 12 ghz
// [R13] device picks one of 512 vco bands automatically and tracks it
// [R14] host writes the three vco tracking registers for its frequency range
// [R15] host programs everything in order, then sets control bit 4 to enable
// [R16] lock is reported in bit 1 of the synth status register
// [R17] band edge hits flag status bits 7:6; host recalibrates via control bit 7
// [R18] lock and lost events enabled by bits 5:4, status and clear at bits 5:4
// [R19] enabled event rising edge latches its source; irq pin low while any latched
// [R20] status reads latched source when enabled, live event level when not
// [R21] lock event on lock rising, lost event on lock falling after being set

module dpcc_top
  import dpcc_pkg::*;
#(
  parameter int CAL_CYCLES = `DPCC_CAL_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // serial port
  input  wire logic        spi_sclk,
  input  wire logic        spi_csn,
  input  wire logic        spi_sdi,
  output wire logic        spi_sdo,
  output wire logic        spi_sdo_oe,
  // interrupt pin, open drain, pulled low while oe high
  output wire logic        irq_n_oe,
  // analog synthesizer status
  input  wire logic        pll_locked,
  input  wire logic        vco_band_up,
  input  wire logic        vco_band_down,
  // analog synthesizer controls
  output wire logic        clk_sel_pll,
  output wire logic        synth_enable,
  output wire logic        cp_cal_active,
  output wire logic [8:0]  vco_band,
  output wire logic [7:0]  feedback_divide_ratio,
  output wire logic [4:0]  reference_divide_ratio,
  output wire logic [4:0]  vco_output_divide_ratio,
  output wire logic [19:0] loop_filter_codes,
  output wire logic [5:0]  cp_current_code,
  output wire logic [7:0]  vco_track_a,
  output wire logic [7:0]  vco_track_b,
  output wire logic [7:0]  vco_track_c
);

  // ==========================================================
  // decoding
  function automatic logic is_mapped(input logic [14:0] a);
    case (a)
      `DPCC_ADDR_PLL_IRQ_EN, `DPCC_ADDR_PLL_IRQ_STATUS, `DPCC_ADDR_SYNTH_CONTROL,
      `DPCC_ADDR_SYNTH_STATUS, `DPCC_ADDR_FEEDBACK_DIV, `DPCC_ADDR_LOOP_FILTER_A,
      `DPCC_ADDR_LOOP_FILTER_B, `DPCC_ADDR_LOOP_FILTER_C, `DPCC_ADDR_CP_CURRENT,
      `DPCC_ADDR_VCO_OUT_DIV, `DPCC_ADDR_REF_DIV, `DPCC_ADDR_VCO_TRACK_A,
      `DPCC_ADDR_VCO_TRACK_B, `DPCC_ADDR_VCO_TRACK_C: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  dpcc_state_s q_r;
  dpcc_state_s q_nxt;

  logic [1:0]  live_ev;
  logic [1:0]  rise_ev;
  logic [7:0]  rd_data;
  logic [23:0] nsh;
  logic [14:0] rd_addr;
  logic [14:0] wr_addr;
  logic [7:0]  wd;
  logic        wr_stb;
  logic        start_cal;
  logic [1:0]  irq_clr;

  // live levels: bit 1 lock, bit 0 lost
  assign live_ev = {q_r.lock, q_r.lock_d & ~q_r.lock};                   // [R21]
  assign rise_ev = {q_r.lock & ~q_r.lock_d, q_r.lock_d & ~q_r.lock};     // [R21]

  // ==========================================================
  // read mux
  always_comb begin
    rd_addr = nsh[14:0];
    rd_data = 8'h00;
    case (rd_addr)
      `DPCC_ADDR_PLL_IRQ_EN:    rd_data[`DPCC_IRQ_LOCK_BIT -: 2] = q_r.irq_en;
      `DPCC_ADDR_PLL_IRQ_STATUS:
        rd_data[`DPCC_IRQ_LOCK_BIT -: 2] =
          (q_r.irq_en & q_r.irq_src) | (~q_r.irq_en & live_ev);           // [R20]
      `DPCC_ADDR_SYNTH_CONTROL: rd_data = q_r.ctrl;
      `DPCC_ADDR_SYNTH_STATUS: begin
        rd_data[`DPCC_STAT_LOCK_BIT]     = q_r.lock;                      // [R16]
        rd_data[`DPCC_STAT_CAL_DONE_BIT] = q_r.cal_done;                  // [R5]
        rd_data[`DPCC_STAT_EDGE_LO_BIT]  = q_r.edge_lo;                   // [R17]
        rd_data[`DPCC_STAT_EDGE_HI_BIT]  = q_r.edge_hi;                   // [R17]
      end
      `DPCC_ADDR_FEEDBACK_DIV:  rd_data = q_r.fb;
      `DPCC_ADDR_LOOP_FILTER_A: rd_data = q_r.lfa;
      `DPCC_ADDR_LOOP_FILTER_B: rd_data = q_r.lfb;
      `DPCC_ADDR_LOOP_FILTER_C: rd_data = q_r.lfc;
      `DPCC_ADDR_CP_CURRENT:    rd_data = {2'h0, q_r.cp};
      `DPCC_ADDR_VCO_OUT_DIV:   rd_data = {6'h00, q_r.vco_code};
      `DPCC_ADDR_REF_DIV:       rd_data = {5'h00, q_r.ref_code};
      `DPCC_ADDR_VCO_TRACK_A:   rd_data = q_r.tra;
      `DPCC_ADDR_VCO_TRACK_B:   rd_data = q_r.trb;
      `DPCC_ADDR_VCO_TRACK_C:   rd_data = q_r.trc;
      default:                  rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    q_nxt     = q_r;
    nsh       = {q_r.shift[22:0], spi_sdi};
    wr_addr   = nsh[22:8];
    wd        = nsh[7:0];
    wr_stb    = 1'b0;
    start_cal = 1'b0;
    irq_clr   = 2'b00;
    q_nxt.sclk_d = spi_sclk;

    // serial port: 16-bit instruction (read flag, 15-bit address), one data byte
    if (spi_csn) begin
      q_nxt.bit_cnt = 5'h00;
      q_nxt.sdo_oe  = 1'b0;
    end else if (spi_sclk & ~q_r.sclk_d) begin
      q_nxt.shift = nsh;
      if (q_r.bit_cnt != 5'd24) begin
        q_nxt.bit_cnt = q_r.bit_cnt + 5'h01;
      end
      if (q_r.bit_cnt == 5'd15 && nsh[15]) begin
        // first data bit must be on the pin before the next rising edge
        q_nxt.sdo    = rd_data[7];
        q_nxt.out_sh = rd_data[6:0];
        q_nxt.sdo_oe = 1'b1;
      end
      if (q_r.bit_cnt == 5'd23) begin
        wr_stb = ~nsh[23] & is_mapped(wr_addr);
      end
    end else if (~spi_sclk & q_r.sclk_d & q_r.sdo_oe) begin
      if (q_r.bit_cnt == 5'd24) begin
        q_nxt.sdo_oe = 1'b0;
      end else if (q_r.bit_cnt > 5'd16) begin
        q_nxt.sdo    = q_r.out_sh[6];
        q_nxt.out_sh = {q_r.out_sh[5:0], 1'b0};
      end
    end

    // register writes
    if (wr_stb) begin
      case (wr_addr)
        `DPCC_ADDR_PLL_IRQ_EN:    q_nxt.irq_en = wd[`DPCC_IRQ_LOCK_BIT -: 2];  // [R18]
        `DPCC_ADDR_PLL_IRQ_STATUS: irq_clr = wd[`DPCC_IRQ_LOCK_BIT -: 2];      // [R18]
        `DPCC_ADDR_SYNTH_CONTROL: begin
          q_nxt.ctrl = wd;
          // calibrate on first enable and on every 0-to-1 of the recal bit written together with the enable bit set
          start_cal = wd[`DPCC_CTRL_ENABLE_BIT] &
                      ((~q_r.ever_en & ~q_r.ctrl[`DPCC_CTRL_ENABLE_BIT]) |
                       (wd[`DPCC_CTRL_RECAL_BIT] & ~q_r.ctrl[`DPCC_CTRL_RECAL_BIT]));  // [R5]
        end
        `DPCC_ADDR_FEEDBACK_DIV: begin
          // out-of-range ratios are dropped so the divider never sees them
          if (wd >= `DPCC_FB_MIN && wd <= `DPCC_FB_MAX) begin
            q_nxt.fb = wd;                                                // [R9]
          end
        end
        `DPCC_ADDR_LOOP_FILTER_A: q_nxt.lfa = wd;                         // [R3]
        `DPCC_ADDR_LOOP_FILTER_B: q_nxt.lfb = wd;                         // [R3]
        `DPCC_ADDR_LOOP_FILTER_C: q_nxt.lfc = wd;                         // [R3]
        `DPCC_ADDR_CP_CURRENT:    q_nxt.cp  = wd[5:0];                    // [R4]
        `DPCC_ADDR_VCO_OUT_DIV: begin
          if (wd[1:0] != 2'h0) begin
            q_nxt.vco_code  = wd[1:0];
            q_nxt.vco_ratio = 5'(5'h02 << wd[1:0]);                       // [R11]
          end
        end
        `DPCC_ADDR_REF_DIV: begin
          if (wd[2:0] <= `DPCC_REF_CODE_MAX) begin
            q_nxt.ref_code  = wd[2:0];
            q_nxt.ref_ratio = 5'(5'h01 << wd[2:0]);                       // [R7]
          end
        end
        `DPCC_ADDR_VCO_TRACK_A:   q_nxt.tra = wd;
        `DPCC_ADDR_VCO_TRACK_B:   q_nxt.trb = wd;
        `DPCC_ADDR_VCO_TRACK_C:   q_nxt.trc = wd;
        default: ;
      endcase
    end

    // sequencer
    case (q_r.st)
      DPCC_IDLE: begin
        if (start_cal) begin
          q_nxt.st = DPCC_CAL;
        end else if (q_r.ctrl[`DPCC_CTRL_ENABLE_BIT] & q_r.cal_done) begin
          q_nxt.st = DPCC_RUN;
        end
      end
      DPCC_CAL: begin
        q_nxt.cal_cnt = q_r.cal_cnt + 16'h0001;
        if (q_r.cal_cnt == 16'(CAL_CYCLES - 1)) begin
          q_nxt.st       = DPCC_RUN;
          q_nxt.cal_done = 1'b1;                                          // [R5]
        end
      end
      DPCC_RUN: begin
        if (~q_r.ctrl[`DPCC_CTRL_ENABLE_BIT]) begin
          q_nxt.st = DPCC_IDLE;
        end else if (vco_band_up) begin
          if (q_r.band == `DPCC_BAND_MAX) q_nxt.edge_hi = 1'b1;           // [R17]
          else q_nxt.band = q_r.band + 9'h001;                            // [R13]
        end else if (vco_band_down) begin
          if (q_r.band == 9'h000) q_nxt.edge_lo = 1'b1;                   // [R17]
          else q_nxt.band = q_r.band - 9'h001;                            // [R13]
        end
      end
      default: q_nxt.st = DPCC_IDLE;
    endcase
    if (start_cal) begin
      // a fresh calibration restarts the band search from mid range
      q_nxt.st       = DPCC_CAL;
      q_nxt.cal_cnt  = 16'h0000;
      q_nxt.cal_done = 1'b0;
      q_nxt.band     = `DPCC_BAND_MID;
      q_nxt.edge_hi  = 1'b0;
      q_nxt.edge_lo  = 1'b0;
      q_nxt.ever_en  = 1'b1;
    end

    // lock status and interrupt sources
    q_nxt.lock   = pll_locked & (q_r.st == DPCC_RUN) & q_r.ctrl[`DPCC_CTRL_ENABLE_BIT];  // [R16]
    q_nxt.lock_d = q_r.lock;
    for (int i = 0; i < 2; i++) begin
      // a new event beats a clear in the same cycle
      q_nxt.irq_src[i] = q_r.irq_en[i] &
                         ((q_r.irq_src[i] & ~irq_clr[i]) | rise_ev[i]);   // [R19]
    end
    q_nxt.irq_oe      = |q_r.irq_src;                                     // [R19]
    q_nxt.clk_sel_pll = q_r.lock;                                         // [R1]
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock) begin
    if (srst) begin
      q_r           <= '0;
      q_r.st        <= DPCC_IDLE;
      q_r.fb        <= `DPCC_RST_FEEDBACK;
      q_r.vco_code  <= `DPCC_RST_VCO_CODE;
      q_r.vco_ratio <= 5'(5'h02 << `DPCC_RST_VCO_CODE);
      q_r.ref_code  <= `DPCC_RST_REF_CODE;
      q_r.ref_ratio <= 5'(5'h01 << `DPCC_RST_REF_CODE);
      q_r.band      <= `DPCC_BAND_MID;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign spi_sdo                 = q_r.sdo;
  assign spi_sdo_oe              = q_r.sdo_oe;
  assign irq_n_oe                = q_r.irq_oe;
  assign clk_sel_pll             = q_r.clk_sel_pll;   // [R1]
  assign synth_enable            = q_r.ctrl[`DPCC_CTRL_ENABLE_BIT];
  assign cp_cal_active           = q_r.st == DPCC_CAL;
  assign vco_band                = q_r.band;
  // the phase detector divides the sample clock by twice this ratio
  assign feedback_divide_ratio   = q_r.fb;            // [R10]
  assign reference_divide_ratio  = q_r.ref_ratio;
  assign vco_output_divide_ratio = q_r.vco_ratio;
  assign loop_filter_codes       = {q_r.lfc[3:0], q_r.lfb, q_r.lfa};   // [R3]
  assign cp_current_code         = q_r.cp;            // [R4]
  assign vco_track_a             = q_r.tra;
  assign vco_track_b             = q_r.trb;
  assign vco_track_c             = q_r.trc;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  cal_length_a: assert property ($rose(q_r.st == DPCC_CAL) |->     // [R5]
      !q_r.cal_done [*8])
    else $error("calibration done too early");
  cal_done_a: assert property ((q_r.st == DPCC_CAL &&
      q_r.cal_cnt == 16'(CAL_CYCLES - 1) && !start_cal) |=> q_r.cal_done)   // [R5]
    else $error("calibration done flag missing");
  fb_range_a: assert property (q_r.fb >= `DPCC_FB_MIN && q_r.fb <= `DPCC_FB_MAX)  // [R9]
    else $error("feedback ratio out of range");
  ref_ratio_a: assert property (q_r.ref_ratio == 5'(5'h01 << q_r.ref_code))  // [R7]
    else $error("reference ratio does not match code");
  vco_ratio_a: assert property (q_r.vco_code != 2'h0 &&               // [R11]
      q_r.vco_ratio == 5'(5'h02 << q_r.vco_code))
    else $error("vco ratio does not match code");
  lock_gate_a: assert property (q_r.lock |-> $past(pll_locked) &&     // [R16]
      $past(q_r.ctrl[`DPCC_CTRL_ENABLE_BIT]))
    else $error("lock reported without lock and enable");
  irq_latch_a: assert property ((q_r.irq_en[1] && $rose(q_r.lock))   // [R19]
      |=> q_r.irq_src[1])
    else $error("lock event not latched");
  lost_latch_a: assert property ((q_r.irq_en[0] && $fell(q_r.lock)) // [R21]
      |=> q_r.irq_src[0])
    else $error("lost event not latched");
  irq_pin_a: assert property ((|q_r.irq_src) |=> irq_n_oe)           // [R19]
    else $error("interrupt pin not pulled");
  irq_off_a: assert property (!q_r.irq_en[1] |=> !q_r.irq_src[1])    // [R18]
    else $error("disabled source still latched");
  band_step_a: assert property ((q_r.st == DPCC_RUN && q_r.ctrl[`DPCC_CTRL_ENABLE_BIT] && // [R13]
      vco_band_up && q_r.band != `DPCC_BAND_MAX && !start_cal)
      |=> q_r.band == $past(q_r.band) + 9'h001)
    else $error("band step up missing");
  edge_hold_a: assert property (q_r.edge_hi && !start_cal |=> q_r.edge_hi)  // [R17]
    else $error("band edge flag lost before recal");

  cal_run_c: cover property (q_r.st == DPCC_CAL ##1 q_r.st == DPCC_RUN);
  irq_fire_c: cover property ($rose(irq_n_oe));
  edge_hit_c: cover property ($rose(q_r.edge_hi) || $rose(q_r.edge_lo));
  spi_read_c: cover property ($fell(spi_sdo_oe));

endmodule // dpcc_top

// ==== tb/dpcc_pll_model.sv ====
// stand-in for the analog synthesizer: lock indication behind the control outputs
`timescale 1ns/1ns
module dpcc_pll_model #(
  parameter int LOCK_DELAY = 6
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // controls from the block, and drop_lock from the bench
  input  wire logic synth_enable,
  input  wire logic cp_cal_active,
  input  wire logic drop_lock,
  // status to the block
  output wire logic pll_locked
);
  // ==========================================================
  // lock settles only some cycles after calibration, as a real loop pulls in
  logic [7:0] settle_r;
  always_ff @(posedge clock) begin
    if (srst || !synth_enable || cp_cal_active || drop_lock) begin
      settle_r <= 8'h00;
    end else if (settle_r != 8'(LOCK_DELAY)) begin
      settle_r <= settle_r + 8'h01;
    end
  end
  assign pll_locked = (settle_r == 8'(LOCK_DELAY));
endmodule // dpcc_pll_model

// ==== tb/dpcc_top_bench.sv ====
// self-checking bench of the pll clock config block
`timescale 1ns/1ns
`include "dpcc_regs.svh"
module dpcc_top_bench;
  import dpcc_pkg::*;
  localparam int CAL = 8;
  typedef struct { logic [14:0] a; logic [7:0] d; logic [7:0] e; } dpcc_row_s;
  // ==========================================================
  // signals
  logic        clock, srst, spi_sclk, spi_csn, spi_sdi, drop_lock;
  logic        vco_band_up, vco_band_down, pll_locked, spi_sdo, spi_sdo_oe, irq_n_oe;
  logic        clk_sel_pll, synth_enable, cp_cal_active;
  logic [8:0]  vco_band;
  logic [7:0]  fb_ratio, trk_a, trk_b, trk_c, rv;
  logic [4:0]  ref_ratio, vco_ratio;
  logic [19:0] lf_codes;
  logic [5:0]  cp_code;
  int          n_errors, comparisons, cal_seen;
  dpcc_row_s   rows [15];
  // ==========================================================
  // design and far side
  dpcc_top #(.CAL_CYCLES(CAL)) uut (
    .clock(clock), .srst(srst), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .irq_n_oe(irq_n_oe),
    .pll_locked(pll_locked), .vco_band_up(vco_band_up), .vco_band_down(vco_band_down),
    .clk_sel_pll(clk_sel_pll), .synth_enable(synth_enable), .cp_cal_active(cp_cal_active),
    .vco_band(vco_band), .feedback_divide_ratio(fb_ratio),
    .reference_divide_ratio(ref_ratio), .vco_output_divide_ratio(vco_ratio),
    .loop_filter_codes(lf_codes), .cp_current_code(cp_code),
    .vco_track_a(trk_a), .vco_track_b(trk_b), .vco_track_c(trk_c));
  dpcc_pll_model pll (
    .clock(clock), .srst(srst), .synth_enable(synth_enable),
    .cp_cal_active(cp_cal_active), .drop_lock(drop_lock), .pll_locked(pll_locked));
  always #50 clock = ~clock;
  // calibration length is counted in cycles of cp_cal_active
  always @(posedge clock) begin
    if (cp_cal_active === 1'b1) begin
      cal_seen++;
    end
  end
  // ==========================================================
  // tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string w);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, w, seen, exp);
    end
  endtask
  // mode 0, msb first; sclk levels held 3 clocks, read bits taken just before each rise
  task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] w;
    w = {r, a, d};
    rv = 8'h00;
    @(negedge clock);
    spi_csn = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = w[i];
      repeat (3) @(negedge clock);
      if (i < 8) rv[i] = spi_sdo;
      spi_sclk = 1'b1;
      repeat (3) @(negedge clock);
      spi_sclk = 1'b0;
    end
    repeat (3) @(negedge clock);
    spi_csn = 1'b1;
    repeat (4) @(negedge clock);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi(1'b0, a, d);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e, input string w);
    spi(1'b1, a, 8'h00);
    check(rv, e, w);
  endtask
  task automatic pulse_band(input logic up);
    vco_band_up = up;
    vco_band_down = !up;
    @(negedge clock);
    vco_band_up = 1'b0;
    vco_band_down = 1'b0;
    @(negedge clock);
  endtask
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog: the whole run needs about 9500 cycles
  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    stop_test;
  end
  // ==========================================================
  // main sequence
  initial begin
    clock = 1'b0; srst = 1'b1; spi_sclk = 1'b0; spi_csn = 1'b1; spi_sdi = 1'b0;
    drop_lock = 1'b0; vco_band_up = 1'b0; vco_band_down = 1'b0;
    n_errors = 0; comparisons = 0; cal_seen = 0;
    // fixed writes first, then vco divider, feedback, reference, tracking
    // refused codes leave the last code of the sweeps above (vco 3, ref 4)
    // ref /8, ratio 16, vco /8: a 368.64 mhz reference gives 46 mhz and an 11.8 ghz vco
    rows = '{'{15'h87, 8'h62, 8'h62}, '{15'h88, 8'hc9, 8'hc9}, '{15'h89, 8'h0e, 8'h0e},
             '{15'h8a, 8'h12, 8'h12}, '{15'h8b, 8'h00, 8'h03}, '{15'h8b, 8'h02, 8'h02},
             '{15'h85, 8'h05, 8'h08}, '{15'h85, 8'h80, 8'h08}, '{15'h85, 8'h10, 8'h10},
             '{15'h8c, 8'h05, 8'h04}, '{15'h8c, 8'h03, 8'h03}, '{15'h1b4, 8'h78, 8'h78},
             '{15'h1b6, 8'h4d, 8'h4d}, '{15'h1bb, 8'h04, 8'h04}, '{15'h100, 8'h55, 8'h00}};
    repeat (12) @(negedge clock);
    srst = 1'b0;
    check({vco_band, fb_ratio, ref_ratio, vco_ratio}, {9'h100, 8'h08, 5'h01, 5'h04}, "rst cfg");
    check({synth_enable, clk_sel_pll, irq_n_oe, spi_sdo_oe}, 4'h0, "rst ctl");
    $display("test reset done");
    for (int c = 0; c <= 4; c++) begin
      wr(`DPCC_ADDR_REF_DIV, 8'(c));
      check(ref_ratio, 32'd1 << c, "ref ratio");
    end
    for (int c = 1; c <= 3; c++) begin
      wr(`DPCC_ADDR_VCO_OUT_DIV, 8'(c));
      check(vco_ratio, 32'd2 << c, "vco ratio");
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "reg row");
    end
    check({lf_codes, cp_code, fb_ratio}, {20'he_c962, 6'h12, 8'h10}, "cfg ports");
    check({trk_a, trk_b, trk_c, ref_ratio, vco_ratio}, {24'h784d04, 5'h08, 5'h08}, "cfg2");
    $display("test table done");
    // first enable calibrates, then locks and raises the lock event
    wr(`DPCC_ADDR_PLL_IRQ_EN, 8'h30);
    rd(`DPCC_ADDR_SYNTH_STATUS, 8'h00, "status idle");
    wr(`DPCC_ADDR_SYNTH_CONTROL, 8'h10);
    wr(`DPCC_ADDR_SYNTH_STATUS, 8'hff);
    rd(`DPCC_ADDR_SYNTH_STATUS, 8'h22, "status run");
    check(cal_seen, CAL, "cal length");
    check({synth_enable, clk_sel_pll, irq_n_oe}, 3'h7, "locked");
    rd(`DPCC_ADDR_PLL_IRQ_STATUS, 8'h20, "lock src");
    wr(`DPCC_ADDR_PLL_IRQ_STATUS, 8'h20);
    check(irq_n_oe, 1'b0, "lock clr");
    drop_lock = 1'b1;
    rd(`DPCC_ADDR_SYNTH_STATUS, 8'h20, "unlocked");
    rd(`DPCC_ADDR_PLL_IRQ_STATUS, 8'h10, "lost src");
    check({irq_n_oe, clk_sel_pll}, 2'h2, "lost irq");
    wr(`DPCC_ADDR_PLL_IRQ_STATUS, 8'h10);
    check(irq_n_oe, 1'b0, "lost clr");
    drop_lock = 1'b0;
    repeat (20) @(negedge clock);
    check(irq_n_oe, 1'b1, "relock irq");
    wr(`DPCC_ADDR_PLL_IRQ_EN, 8'h00);
    check(irq_n_oe, 1'b0, "mask clr");
    rd(`DPCC_ADDR_PLL_IRQ_STATUS, 8'h20, "live lock");
    drop_lock = 1'b1;
    repeat (10) @(negedge clock);
    check(irq_n_oe, 1'b0, "masked lost");
    rd(`DPCC_ADDR_PLL_IRQ_STATUS, 8'h00, "live lost");
    drop_lock = 1'b0;
    $display("test lock events done");
    // band walk up to the upper edge, then host recalibration
    for (int k = 0; k < 256; k++) begin
      pulse_band(1'b1);
    end
    check(vco_band, 9'h1ff, "band top");
    rd(`DPCC_ADDR_SYNTH_STATUS, 8'ha2, "edge hi");
    pulse_band(1'b0);
    check(vco_band, 9'h1fe, "band down");
    cal_seen = 0;
    wr(`DPCC_ADDR_SYNTH_CONTROL, 8'h10);
    wr(`DPCC_ADDR_SYNTH_CONTROL, 8'h90);
    rd(`DPCC_ADDR_SYNTH_STATUS, 8'h22, "recal");
    check(cal_seen, CAL, "recal length");
    // re-enable after a disable keeps the earlier calibration
    cal_seen = 0;
    wr(`DPCC_ADDR_SYNTH_CONTROL, 8'h00);
    check(synth_enable, 1'b0, "disabled");
    wr(`DPCC_ADDR_SYNTH_CONTROL, 8'h10);
    rd(`DPCC_ADDR_SYNTH_STATUS, 8'h22, "reenable");
    check(cal_seen, 0, "no recal");
    $display("test band done");
    // second reset in mid-run
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    check({vco_band, synth_enable, fb_ratio}, {9'h100, 1'b0, 8'h08}, "rerst");
    rd(`DPCC_ADDR_SYNTH_STATUS, 8'h00, "rerst status");
    $display("test mid reset done");
    stop_test;
  end
endmodule // dpcc_top_bench
